// file: common/window_watchdog_pkg.sv
// Notes on behaviour
// - Counter steps down once every 12288 clock cycles.
// - While active, reset request when counter top bit falls from 0x40 to 0x3f.
// - Control register: counter in bits 6..0, activation bit in bit 7.
// - Activation bit set by software only, cleared only by reset.
// - Hardware option makes watchdog always active, activation bit ignored.
// - Window register holds 7-bit limit compared against the counter.
// - Wait mode changes nothing; counter keeps stepping.
// - Halt with option 0: one more step, then frozen, no reset until wake.
// - Interrupt wake from halt resumes counting after stabilization delay.
// - Reset ending halt leaves watchdog disabled unless hardware option set.
// - While active, halt with option 1 produces a reset instead of halting.
// - Active-halt: no reset, counter frozen.
// - Interrupt wake from active-halt resumes counting immediately.
// - Reset ending active-halt resumes counting after stabilization delay.
// - While active, refresh while counter above window limit generates reset.
// - Counter keeps running even while watchdog disabled.
package watchdog_pkg;
	localparam logic [1:0] REG_CONTROL_COUNTER = 2'h0;
	localparam logic [1:0] REG_WINDOW_LIMIT = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam logic [3:0] CONTROL_COUNTER_ADDR = 4'h0;
	localparam logic [3:0] WINDOW_LIMIT_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR = 4'h8;
	localparam int ACT_BIT = 7;
	localparam int TOP_BIT = 6;
	localparam logic [6:0] COUNT_RESET = 7'h7f;
	localparam logic [6:0] WINDOW_RESET = 7'h7f;
	localparam logic [6:0] COUNT_FLOOR = 7'h3f;
	localparam int TICK_CYCLES = 12288;
	localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);
	localparam int STAB_CYCLES = 16;
	localparam logic [7:0] STAB_LAST = 8'(STAB_CYCLES - 1);
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_HALT_STEP = 3'b001,
		ST_HALT_FROZEN = 3'b010,
		ST_ACTIVE_HALT = 3'b011,
		ST_STAB = 3'b100
	} pm_state_t;
endpackage

// file: design/window_watchdog_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Two-word register store, registered read data
module watchdog_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_r [0:1];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_r[0] <= 8'h00;
			mem_r[1] <= 8'h00;
			rdata_o <= 8'h00;
		end else begin
			if (we_i) begin
				mem_r[waddr_i] <= wdata_i;
			end
			rdata_o <= mem_r[raddr_i];
		end
	end
endmodule
`default_nettype wire

// file: design/window_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module window_watchdog
	import watchdog_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic hw_watchdog_opt_i,
	input wire logic halt_reset_option_i,
	input wire logic halt_exec_i,
	input wire logic active_halt_i,
	input wire logic wake_irq_i,
	input wire logic reset_wake_i,
	output logic reset_req_o,
	output logic counting_o
);
	typedef struct packed {
		logic [13:0] presc;
		logic [6:0] count;
		logic activation_bit;
		logic [6:0] window;
		pm_state_t pm;
		logic [7:0] stab;
		logic ack;
		logic [31:0] dat;
		logic rst_req;
		logic counting;
		logic rd_sel;
	} state_t;
	state_t st_r;
	state_t st_nxt;
	logic [7:0] shadow_rdata;
	////////////////////////////////////////////////////////////////////////
	// Bus decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] base);
		return a == base;
	endfunction
	logic req;
	logic wr_ctl;
	logic wr_win;
	assign req = cyc_i && stb_i && !st_r.ack;
	assign wr_ctl = req && we_i && sel_i[0] && hit(adr_i, CONTROL_COUNTER_ADDR);
	assign wr_win = req && we_i && sel_i[0] && hit(adr_i, WINDOW_LIMIT_ADDR);
	// Shadow copy of last written words; only word 0 is read back, into rd_sel, never onto the bus
	watchdog_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr_ctl || wr_win),
		.waddr_i(wr_win),
		.wdata_i(dat_i[7:0]),
		.raddr_i(1'b0),
		.rdata_o(shadow_rdata)
	);
	////////////////////////////////////////////////////////////////////////
	// Next state
	logic armed;
	logic tick;
	logic run;
	always_comb begin
		st_nxt = st_r;
		st_nxt.rst_req = 1'b0;
		st_nxt.ack = req;
		armed = hw_watchdog_opt_i || st_r.activation_bit;
		tick = st_r.presc == TICK_LAST;
		st_nxt.presc = tick ? 14'h0000 : st_r.presc + 14'h0001;
		run = (st_r.pm == ST_RUN) || (st_r.pm == ST_HALT_STEP);
		if (run && tick) begin
			st_nxt.count = st_r.count - 7'h01;
			if (armed && st_r.count[TOP_BIT] && !st_nxt.count[TOP_BIT] && st_r.pm == ST_RUN) begin
				st_nxt.rst_req = 1'b1;
			end
			if (st_r.pm == ST_HALT_STEP) begin
				st_nxt.pm = ST_HALT_FROZEN;
			end
		end
		case (st_r.pm)
			ST_RUN: begin
				if (active_halt_i) begin
					st_nxt.pm = ST_ACTIVE_HALT;
				end else if (halt_exec_i) begin
					if (halt_reset_option_i && armed) begin
						st_nxt.rst_req = 1'b1;
					end else begin
						st_nxt.pm = ST_HALT_STEP;
					end
				end
			end
			ST_HALT_STEP, ST_HALT_FROZEN: begin
				if (wake_irq_i) begin
					st_nxt.pm = ST_STAB;
					st_nxt.stab = 8'h00;
				end
			end
			ST_ACTIVE_HALT: begin
				if (wake_irq_i) begin
					st_nxt.pm = ST_RUN;
				end else if (reset_wake_i) begin
					st_nxt.pm = ST_STAB;
					st_nxt.stab = 8'h00;
				end
			end
			ST_STAB: begin
				st_nxt.stab = st_r.stab + 8'h01;
				if (st_r.stab == STAB_LAST) begin
					st_nxt.pm = ST_RUN;
				end
			end
			default: st_nxt.pm = ST_RUN;
		endcase
		if (wr_ctl) begin
			if (armed && st_r.count > st_r.window) begin
				st_nxt.rst_req = 1'b1;
			end
			if (dat_i[ACT_BIT] && !dat_i[TOP_BIT]) begin
				st_nxt.rst_req = 1'b1;
			end
			st_nxt.count = dat_i[6:0];
			st_nxt.activation_bit = st_r.activation_bit | dat_i[ACT_BIT];
		end
		if (wr_win) begin
			st_nxt.window = dat_i[6:0];
		end
		st_nxt.rd_sel = shadow_rdata[0];
		st_nxt.dat = 32'h00000000;
		if (req && !we_i) begin
			if (hit(adr_i, CONTROL_COUNTER_ADDR)) begin
				st_nxt.dat = {24'h000000, st_r.activation_bit, st_r.count};
			end else if (hit(adr_i, WINDOW_LIMIT_ADDR)) begin
				st_nxt.dat = {25'h0000000, st_r.window};
			end else if (hit(adr_i, STATUS_ADDR)) begin
				st_nxt.dat = {28'h0000000, st_r.counting, st_r.pm};
			end
		end
		st_nxt.counting = (st_nxt.pm == ST_RUN) || (st_nxt.pm == ST_HALT_STEP);
	end
	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.count <= COUNT_RESET;
			st_r.window <= WINDOW_RESET;
			st_r.pm <= ST_RUN;
			st_r.counting <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign dat_o = st_r.dat;
	assign ack_o = st_r.ack;
	assign reset_req_o = st_r.rst_req;
	assign counting_o = st_r.counting;
	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_tick_run;
		st_r.pm == ST_RUN && st_r.presc == TICK_LAST && !wr_ctl;
	endsequence
	chk_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		s_tick_run |=> st_r.count == $past(st_r.count) - 7'h01) else $error("count step wrong");
	chk_roll_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		s_tick_run ##0 (st_r.count == 7'h40 && (hw_watchdog_opt_i || st_r.activation_bit)) |=> reset_req_o)
		else $error("no reset on rollover");
	chk_act_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.activation_bit |=> st_r.activation_bit) else $error("activation cleared");
	chk_active_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.pm == ST_ACTIVE_HALT |=> st_r.count == $past(st_r.count)) else $error("count moved in active halt");
	chk_halt_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.pm == ST_HALT_FROZEN && !wr_ctl |=> st_r.count == $past(st_r.count) && !reset_req_o)
		else $error("count moved in halt");
	chk_pulse_single: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_req_o |=> !reset_req_o) else $error("reset pulse too long");
	chk_window_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && (hw_watchdog_opt_i || st_r.activation_bit) && st_r.count > st_r.window |=> reset_req_o)
		else $error("early refresh not punished");
	chk_wake_fast: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.pm == ST_ACTIVE_HALT && wake_irq_i |=> counting_o) else $error("slow active halt wake");
	chk_halt_opt: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.pm == ST_RUN && !active_halt_i && halt_exec_i && halt_reset_option_i && st_r.activation_bit
		|=> reset_req_o) else $error("no halt reset");
endmodule
`default_nettype wire

// file: verif/sys_reset_model.sv
`timescale 1ns/1ps
`default_nettype none
// System reset controller: stretches each request into a short reset
module sys_reset_model (
	input wire logic clk_i,
	input wire logic req_i,
	output logic rst_o,
	output logic [7:0] hits_o
);
	logic [2:0] cnt_r = 3'h0;
	logic [7:0] hits_r = 8'h00;
	////////////////////////////////////////
	assign rst_o = (cnt_r != 3'h0);
	assign hits_o = hits_r;
	always_ff @(posedge clk_i) begin
		if (req_i) begin
			cnt_r <= 3'h4;
			hits_r <= hits_r + 8'h01;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import watchdog_pkg::*;
	logic clk_i, ext_rst, cyc, stb, we, hw, hro, hlt, ah, wk, rwk, ack, req, cnt, srst;
	logic [3:0] adr;
	logic [31:0] wd, dout, rd, lfsr;
	logic [7:0] hits;
	int miscompares, total_checks, eh, n;
	wire logic rst_i = ext_rst | srst;
	window_watchdog i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'h1), .dat_i(wd), .dat_o(dout), .ack_o(ack), .hw_watchdog_opt_i(hw), .halt_reset_option_i(hro),
		.halt_exec_i(hlt), .active_halt_i(ah), .wake_irq_i(wk), .reset_wake_i(rwk), .reset_req_o(req),
		.counting_o(cnt));
	sys_reset_model i_sys (.clk_i(clk_i), .req_i(req), .rst_o(srst), .hits_o(hits));
	////////////////////////////////////////
	function automatic logic [31:0] ctl(input logic act, input int ticks);
		return {24'h0, act, 7'(COUNT_RESET - ticks)};
	endfunction
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h80200003)};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic look(input int k);
		repeat (k) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			miscompares++;
			complete_run();
		end else begin
			rd = dout;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(rd, exp);
	endtask
	task automatic after_rst();
		look(8);
		check(32'(hits), 32'(eh));
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b0, 0));
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_i);
		{ext_rst, hlt, ah, wk, rwk} <= m;
		@(posedge clk_i);
		{ext_rst, hlt, ah, wk, rwk} <= 5'h00;
	endtask
	task automatic opts(input logic h, input logic o);
		@(posedge clk_i);
		hw <= h;
		hro <= o;
	endtask
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		{ext_rst, cyc, stb, we, hw, hro, hlt, ah, wk, rwk} = 10'h200;
		adr = 4'h0;
		wd = 32'h0;
		lfsr = 32'h6517d79f;
		miscompares = 0;
		total_checks = 0;
		eh = 0;
		repeat (6) @(posedge clk_i);
		ext_rst <= 1'b0;
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b0, 0));
		rdchk(WINDOW_LIMIT_ADDR, 32'h7f);
		rdchk(4'hc, 32'h0);
		look(12300);
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b0, 1));
		repeat (4) begin
			lfsr = step(lfsr);
			bus(1'b1, WINDOW_LIMIT_ADDR, {1'b0, lfsr[6:0]});
			rdchk(WINDOW_LIMIT_ADDR, {25'h0, lfsr[6:0]});
		end
		bus(1'b1, WINDOW_LIMIT_ADDR, 8'h7f);
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hff);
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'h7f);
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b1, 0));
		bus(1'b1, WINDOW_LIMIT_ADDR, 8'h50);
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hff);
		eh++;
		after_rst();
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'h80);
		eh++;
		after_rst();
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hff);
		opts(1'b0, 1'b1);
		pulse(5'h08);
		eh++;
		after_rst();
		opts(1'b1, 1'b1);
		pulse(5'h08);
		eh++;
		after_rst();
		opts(1'b0, 1'b0);
		pulse(5'h04);
		look(1);
		check(32'(cnt), 32'h0);
		pulse(5'h02);
		look(1);
		check(32'(cnt), 32'h1);
		pulse(5'h04);
		pulse(5'h01);
		look(4);
		check(32'(cnt), 32'h0);
		look(STAB_CYCLES);
		check(32'(cnt), 32'h1);
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hff);
		pulse(5'h08);
		for (int i = 0; i < 13000 && cnt !== 1'b0; i++) look(0);
		if (cnt !== 1'b0) begin
			miscompares++;
			complete_run();
		end
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b1, 1));
		look(12300);
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b1, 1));
		check(32'(hits), 32'(eh));
		pulse(5'h02);
		look(4);
		check(32'(cnt), 32'h0);
		look(STAB_CYCLES);
		check(32'(cnt), 32'h1);
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hc1);
		for (int i = 0; i < 25000 && 32'(hits) == 32'(eh); i++) look(0);
		if (32'(hits) == 32'(eh)) begin
			miscompares++;
			complete_run();
		end
		eh++;
		after_rst();
		bus(1'b1, CONTROL_COUNTER_ADDR, 8'hff);
		pulse(5'h08);
		pulse(5'h10);
		rdchk(CONTROL_COUNTER_ADDR, ctl(1'b0, 0));
		complete_run();
	end
endmodule
`default_nettype wire
